// >>> rtl/sadc_defines.svh
`ifndef SADC_DEFINES_SVH
`define SADC_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define SADC_ADDR_CTRL    8'h00
`define SADC_ADDR_RESULT  8'h04
`define SADC_ADDR_CLKCFG  8'h08

// ----------------------------------------------------------------------
// status and control field positions
// ----------------------------------------------------------------------
`define SADC_CTRL_FLAG    7
`define SADC_CTRL_IRQEN   6
`define SADC_CTRL_CONT    5
`define SADC_CTRL_CHAN_HI 4
`define SADC_CHAN_OFF     5'h1F
`define SADC_CTRL_RST     8'h1F

// ----------------------------------------------------------------------
// clock configuration field positions
// ----------------------------------------------------------------------
`define SADC_CLK_PRESC_HI 7
`define SADC_CLK_PRESC_LO 5
`define SADC_CLK_SRC      4
`define SADC_CLKCFG_RST   8'h00

// ----------------------------------------------------------------------
// conversion timing in converter clock ticks
// ----------------------------------------------------------------------
`define SADC_SAMPLE_LAST  4'h7
`define SADC_CONV_LAST    4'hF
`define SADC_SAR_MSB      8'h80

// ----------------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------------
`define SADC_RESP_OKAY    2'h0
`define SADC_RESP_SLVERR  2'h2

`endif

// >>> rtl/sadc_pkg.sv
package sadc_pkg;

  // ----------------------------------------------------------------------
  // conversion sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SADC_IDLE    = 2'b00,
    SADC_SETTLE  = 2'b01,
    SADC_CONVERT = 2'b10
  } sadc_fsm_type;

  // bus slave side
  typedef struct packed {
    logic       aw_hold;
    logic [7:0] aw_addr;
    logic       w_hold;
    logic [7:0] w_data;
    logic       w_lane0;
    logic       awready;
    logic       wready;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arready;
    logic       rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } sadc_bus_type;

  // software visible registers
  typedef struct packed {
    logic       flag;
    logic       irq_en;
    logic       cont;
    logic [4:0] chan;
    logic [2:0] presc;
    logic       clk_src;
    logic [7:0] result;
  } sadc_regs_type;

  // converter sequencing
  typedef struct packed {
    sadc_fsm_type fsm;
    logic [3:0]   tick;
    logic [3:0]   presc_cnt;
    logic [7:0]   trial;
    logic         settle_req;
    logic         resume;
    logic         first_done;
    logic         pending;
  } sadc_conv_type;

  // synchronisers and registered pin outputs
  typedef struct packed {
    logic       xtal_s1;
    logic       xtal_s2;
    logic       xtal_s3;
    logic [7:0] pad_s1;
    logic [7:0] pad_s2;
    logic [7:0] pad_out;
    logic [7:0] pad_oe;
    logic [7:0] port_read;
    logic [4:0] ana_sel;
    logic       ana_pd;
    logic       cpu_irq;
    logic       dma_req;
    logic       busy;
  } sadc_pins_type;

  typedef struct packed {
    sadc_bus_type  bus;
    sadc_regs_type regs;
    sadc_conv_type conv;
    sadc_pins_type pins;
  } sadc_state_type;

endpackage

// >>> rtl/sadc_top.sv
`timescale 1ns/1ps
`include "sadc_defines.svh"

module sadc_top
  import sadc_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RESET,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        CRYSTAL_CLOCK,
  input  wire logic        STOP_MODE,
  input  wire logic        COMPARATOR,
  input  wire logic [7:0]  PORT_DATA_OUT,
  input  wire logic [7:0]  PORT_DIR_OUT,
  input  wire logic [7:0]  PAD_IN,
  output logic [7:0]       PAD_OUT,
  output logic [7:0]       PAD_OE,
  output logic [7:0]       PORT_READ,
  output logic [4:0]       ANALOG_SELECT,
  output logic [7:0]       ANALOG_TRIAL,
  output logic             ANALOG_POWER_DOWN,
  output logic             CPU_IRQ,
  output logic             DMA_REQ,
  output logic             CONV_BUSY
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------

  // terminal count of the prescaler for each divide setting
  function automatic logic [3:0] presc_limit(input logic [2:0] sel);
    logic [3:0] lim;
    lim = 4'hF;
    case (sel)
      3'h0:    lim = 4'h0;
      3'h1:    lim = 4'h1;
      3'h2:    lim = 4'h3;
      3'h3:    lim = 4'h7;
      default: lim = 4'hF;
    endcase
    return lim;
  endfunction

  // one-hot mask of the port pin taken over by the converter
  function automatic logic [7:0] chan_mask(input logic [4:0] chan);
    logic [7:0] m;
    m = 8'h00;
    if (chan[4:3] == 2'h0)
      m[chan[2:0]] = 1'b1;
    return m;
  endfunction

  // word address match, byte lanes of the address ignored
  function automatic logic addr_hit(input logic [7:0] a,
                                    input logic [7:0] reg_addr);
    return a[7:2] == reg_addr[7:2];
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  sadc_state_type q;
  sadc_state_type d;

  logic           xtal_edge;
  logic           in_tick;
  logic           adc_tick;
  logic           aw_take;
  logic           w_take;
  logic           ar_take;
  logic           do_write;
  logic           ctrl_write;
  logic           clk_write;
  logic           result_read;
  logic           conv_done;
  logic           start_req;
  logic [2:0]     bit_idx;
  logic [7:0]     mask;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    d = q;

    // pin synchronisers; first stage feeds only the second
    d.pins.xtal_s1 = CRYSTAL_CLOCK;
    d.pins.xtal_s2 = q.pins.xtal_s1;
    d.pins.xtal_s3 = q.pins.xtal_s2;
    d.pins.pad_s1  = PAD_IN;
    d.pins.pad_s2  = q.pins.pad_s1;
    xtal_edge      = q.pins.xtal_s2 & ~q.pins.xtal_s3;

    // bus handshakes
    aw_take  = S_AXI_AWVALID & q.bus.awready;
    w_take   = S_AXI_WVALID & q.bus.wready;
    ar_take  = S_AXI_ARVALID & q.bus.arready;
    do_write = q.bus.aw_hold & q.bus.w_hold;
    ctrl_write = do_write & q.bus.w_lane0 &
                 addr_hit(q.bus.aw_addr, `SADC_ADDR_CTRL);
    clk_write  = do_write & q.bus.w_lane0 &
                 addr_hit(q.bus.aw_addr, `SADC_ADDR_CLKCFG);
    result_read = ar_take & addr_hit(S_AXI_ARADDR, `SADC_ADDR_RESULT);

    // write address and data are latched in either order
    if (aw_take)
    begin
      d.bus.aw_hold = 1'b1;
      d.bus.aw_addr = S_AXI_AWADDR;
    end
    if (w_take)
    begin
      d.bus.w_hold  = 1'b1;
      d.bus.w_data  = S_AXI_WDATA[7:0];
      d.bus.w_lane0 = S_AXI_WSTRB[0];
    end
    if (q.bus.bvalid & S_AXI_BREADY)
      d.bus.bvalid = 1'b0;
    if (do_write)
    begin
      d.bus.aw_hold = 1'b0;
      d.bus.w_hold  = 1'b0;
      d.bus.bvalid  = 1'b1;
      d.bus.bresp   = `SADC_RESP_OKAY;
      if (!addr_hit(q.bus.aw_addr, `SADC_ADDR_CTRL) &&
          !addr_hit(q.bus.aw_addr, `SADC_ADDR_RESULT) &&
          !addr_hit(q.bus.aw_addr, `SADC_ADDR_CLKCFG))
        d.bus.bresp = `SADC_RESP_SLVERR;
    end
    d.bus.awready = ~d.bus.aw_hold & ~d.bus.bvalid;
    d.bus.wready  = ~d.bus.w_hold & ~d.bus.bvalid;

    // read channel: one read at a time, data one cycle after address
    if (q.bus.rvalid & S_AXI_RREADY)
      d.bus.rvalid = 1'b0;
    if (ar_take)
    begin
      d.bus.rvalid = 1'b1;
      d.bus.rresp  = `SADC_RESP_OKAY;
      d.bus.rdata  = 8'h00;
      if (addr_hit(S_AXI_ARADDR, `SADC_ADDR_CTRL))
        d.bus.rdata = {q.regs.flag, q.regs.irq_en, q.regs.cont,
                       q.regs.chan};
      else if (result_read)
        d.bus.rdata = q.regs.result;
      else if (addr_hit(S_AXI_ARADDR, `SADC_ADDR_CLKCFG))
        d.bus.rdata = {q.regs.presc, q.regs.clk_src, 4'h0};
      else
        d.bus.rresp = `SADC_RESP_SLVERR;
    end
    d.bus.arready = ~d.bus.rvalid;

    // clock configuration register
    if (clk_write)
    begin
      d.regs.presc   = q.bus.w_data[`SADC_CLK_PRESC_HI:`SADC_CLK_PRESC_LO];
      d.regs.clk_src = q.bus.w_data[`SADC_CLK_SRC];
    end

    // converter clock: bus clock or crystal edges, then prescaler
    in_tick  = q.regs.clk_src ? 1'b1 : xtal_edge;
    adc_tick = in_tick &
               (q.conv.presc_cnt == presc_limit(q.regs.presc));
    if (adc_tick)
      d.conv.presc_cnt = 4'h0;
    else if (in_tick)
      d.conv.presc_cnt = q.conv.presc_cnt + 4'h1;

    // sequencer driven by converter ticks
    conv_done = 1'b0;
    start_req = 1'b0;
    bit_idx   = ~q.conv.tick[2:0];
    case (q.conv.fsm)
      SADC_IDLE:
        d.conv.tick = 4'h0;
      SADC_SETTLE:
      begin
        // one discarded period after power-up or stop
        if (adc_tick)
        begin
          d.conv.tick = q.conv.tick + 4'h1;
          if (q.conv.tick == `SADC_CONV_LAST)
          begin
            d.conv.fsm        = SADC_CONVERT;
            d.conv.tick       = 4'h0;
            d.conv.settle_req = 1'b0;
          end
        end
      end
      SADC_CONVERT:
      begin
        if (adc_tick)
        begin
          d.conv.tick = q.conv.tick + 4'h1;
          if (q.conv.tick == `SADC_SAMPLE_LAST)
            d.conv.trial = `SADC_SAR_MSB;
          else if (q.conv.tick > `SADC_SAMPLE_LAST)
          begin
            // keep the trial bit while input is at or above it
            if (!COMPARATOR)
              d.conv.trial[bit_idx] = 1'b0;
            if (bit_idx != 3'h0)
              d.conv.trial[bit_idx - 3'h1] = 1'b1;
          end
          if (q.conv.tick == `SADC_CONV_LAST)
          begin
            conv_done   = 1'b1;
            d.conv.tick = 4'h0;
            if (!q.regs.cont)
              d.conv.fsm = SADC_IDLE;
          end
        end
      end
      default:
        d.conv.fsm = SADC_IDLE;
    endcase

    // end of conversion: result first, then flag or request
    if (conv_done)
    begin
      d.regs.result     = d.conv.trial;
      d.conv.first_done = 1'b1;
    end

    // clears by software access, applied before the sets
    if (ctrl_write || result_read)
    begin
      d.conv.pending = 1'b0;
      if (!q.regs.irq_en)
      begin
        d.regs.flag = 1'b0;
      end
    end
    if (ctrl_write)
    begin
      d.regs.irq_en = q.bus.w_data[`SADC_CTRL_IRQEN];
      d.regs.cont   = q.bus.w_data[`SADC_CTRL_CONT];
      d.regs.chan   = q.bus.w_data[`SADC_CTRL_CHAN_HI:0];
      d.conv.first_done = 1'b0;
      // selector is writable only while requests are enabled
      d.regs.flag = q.bus.w_data[`SADC_CTRL_IRQEN] &
                    q.bus.w_data[`SADC_CTRL_FLAG];
      start_req = 1'b1;
    end

    // hardware sets win over the same-cycle clears
    if (conv_done && !q.regs.irq_en &&
        (!q.regs.cont || !q.conv.first_done))
    begin
      d.regs.flag = 1'b1;
    end
    if (conv_done && q.regs.irq_en)
    begin
      d.conv.pending = 1'b1;
    end

    // power off, restart and stop handling
    if (STOP_MODE)
    begin
      // abort and freeze; resume later after settling
      if (q.conv.fsm != SADC_IDLE || start_req)
      begin
        d.conv.resume = 1'b1;
      end
      d.conv.fsm        = SADC_IDLE;
      d.conv.presc_cnt  = 4'h0;
      d.conv.settle_req = 1'b1;
    end
    else if (d.regs.chan == `SADC_CHAN_OFF)
    begin
      d.conv.fsm        = SADC_IDLE;
      d.conv.settle_req = 1'b1;
      d.conv.resume     = 1'b0;
    end
    else if (start_req || q.conv.resume)
    begin
      d.conv.fsm    = q.conv.settle_req ? SADC_SETTLE : SADC_CONVERT;
      d.conv.tick   = 4'h0;
      d.conv.trial  = 8'h00;
      d.conv.resume = 1'b0;
      d.conv.presc_cnt = 4'h0;
    end
    else if (conv_done && q.regs.cont)
    begin
      d.conv.trial = 8'h00;
    end

    // pin takeover for the selected channel
    mask = chan_mask(d.regs.chan);
    d.pins.pad_out   = PORT_DATA_OUT & ~mask;
    d.pins.pad_oe    = PORT_DIR_OUT & ~mask;
    d.pins.port_read = q.pins.pad_s2 & ~mask;
    d.pins.ana_sel   = d.regs.chan;
    d.pins.ana_pd    = (d.regs.chan == `SADC_CHAN_OFF) | STOP_MODE;
    d.pins.busy      = d.conv.fsm != SADC_IDLE;

    // requests; an enabled request also serves as wake-up in wait
    d.pins.cpu_irq = d.conv.pending & d.regs.irq_en & ~d.regs.flag;
    d.pins.dma_req = d.conv.pending & d.regs.irq_en & d.regs.flag;
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      q              <= '0;
      q.regs.flag    <= 1'(`SADC_CTRL_RST >> `SADC_CTRL_FLAG);
      q.regs.chan    <= `SADC_CHAN_OFF;
      q.regs.presc   <= 3'(`SADC_CLKCFG_RST >> `SADC_CLK_PRESC_LO);
      q.conv.fsm     <= SADC_IDLE;
      q.conv.settle_req <= 1'b1;
      q.pins.ana_sel <= `SADC_CHAN_OFF;
      q.pins.ana_pd  <= 1'b1;
      q.bus.awready  <= 1'b1;
      q.bus.wready   <= 1'b1;
      q.bus.arready  <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------------
  assign S_AXI_AWREADY     = q.bus.awready;
  assign S_AXI_WREADY      = q.bus.wready;
  assign S_AXI_BVALID      = q.bus.bvalid;
  assign S_AXI_BRESP       = q.bus.bresp;
  assign S_AXI_ARREADY     = q.bus.arready;
  assign S_AXI_RVALID      = q.bus.rvalid;
  assign S_AXI_RRESP       = q.bus.rresp;
  assign S_AXI_RDATA       = {24'h000000, q.bus.rdata};
  assign PAD_OUT           = q.pins.pad_out;
  assign PAD_OE            = q.pins.pad_oe;
  assign PORT_READ         = q.pins.port_read;
  assign ANALOG_SELECT     = q.pins.ana_sel;
  assign ANALOG_TRIAL      = q.conv.trial;
  assign ANALOG_POWER_DOWN = q.pins.ana_pd;
  assign CPU_IRQ           = q.pins.cpu_irq;
  assign DMA_REQ           = q.pins.dma_req;
  assign CONV_BUSY         = q.pins.busy;

endmodule

// >>> dv/sadc_top_monitor.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------
// port level checker for the converter control block
// -----------------------------------------------------------------
module sadc_top_monitor
  import sadc_pkg::*;
(
  input wire logic       CORE_CLK,
  input wire logic       RESET,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic       S_AXI_AWVALID,
  input wire logic       S_AXI_AWREADY,
  input wire logic       S_AXI_BVALID,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic       S_AXI_ARVALID,
  input wire logic       S_AXI_ARREADY,
  input wire logic       STOP_MODE,
  input wire logic [7:0] PAD_OUT,
  input wire logic [7:0] PAD_OE,
  input wire logic [7:0] PORT_READ,
  input wire logic [4:0] ANALOG_SELECT,
  input wire logic       ANALOG_POWER_DOWN,
  input wire logic       CPU_IRQ,
  input wire logic       DMA_REQ,
  input wire logic       CONV_BUSY
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  logic [9:0] busy_q;
  logic       ctrl_q;
  // busy length counter and last write target
  always_ff @(posedge CORE_CLK)
  begin
    busy_q <= CONV_BUSY ? busy_q + 10'h001 : 10'h000;
    if (S_AXI_AWVALID && S_AXI_AWREADY)
      ctrl_q <= (S_AXI_AWADDR[7:2] == 6'h00);
  end
  AST_SEL_PIN_OWNED: assert property (ANALOG_SELECT[4:3] == 2'h0 ##1
    $stable(ANALOG_SELECT)[*2] |-> !PAD_OE[ANALOG_SELECT[2:0]]
    && !PAD_OUT[ANALOG_SELECT[2:0]]) else $error("selected pin driven");
  AST_SEL_READ_ZERO: assert property (ANALOG_SELECT[4:3] == 2'h0 ##1
    $stable(ANALOG_SELECT)[*4] |-> !PORT_READ[ANALOG_SELECT[2:0]])
    else $error("selected pin reads back high");
  AST_IRQ_ONE_KIND: assert property (!(CPU_IRQ && DMA_REQ))
    else $error("both request kinds raised");
  AST_WR_CLEARS_REQ: assert property ($rose(S_AXI_BVALID) && ctrl_q
    |-> ##[0:2] !CPU_IRQ && !DMA_REQ) else $error("request kept on write");
  AST_RD_CLEARS_REQ: assert property (S_AXI_ARVALID && S_AXI_ARREADY
    && S_AXI_ARADDR[7:2] == 6'h01 |-> ##[1:3] !CPU_IRQ)
    else $error("request kept on result read");
  AST_STOP_IDLE: assert property (STOP_MODE && $past(STOP_MODE)
    |-> !CONV_BUSY && ANALOG_POWER_DOWN) else $error("active in stop");
  AST_OFF_POWER: assert property (ANALOG_SELECT == 5'h1F
    && $past(ANALOG_SELECT) == 5'h1F |-> ANALOG_POWER_DOWN)
    else $error("converter powered while off");
  AST_CONV_MIN_TICKS: assert property ($fell(CONV_BUSY) && !STOP_MODE
    |-> busy_q >= 10'h00F) else $error("conversion too short");
  AST_RESET_STATE: assert property ($past(RESET) |->
    ANALOG_SELECT == 5'h1F && ANALOG_POWER_DOWN && !CPU_IRQ && !DMA_REQ
    && !CONV_BUSY) else $error("wrong state after reset");
endmodule
bind sadc_top sadc_top_monitor mon_u (.*);

// >>> dv/sadc_analog_model.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------
// analog sources on the shared port pins
// -----------------------------------------------------------------
module sadc_analog_model
  import sadc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [63:0] levels,
  input  wire logic [4:0]  select,
  input  wire logic [7:0]  trial,
  input  wire logic        power_down,
  input  wire logic [7:0]  pad_out,
  input  wire logic [7:0]  pad_oe,
  output logic             comparator,
  output logic [7:0]       pad_in
);
  logic       junk_q = 1'b0;
  logic [7:0] lvl;
  // unpowered comparator output keeps changing
  always_ff @(posedge clk)
    junk_q <= ~junk_q;
  // comparator decision for the selected source
  always_comb
  begin
    lvl = levels[8*select[2:0] +: 8];
    if (power_down || (select[4:3] != 2'h0 && select < 5'h1D))
      comparator = junk_q;
    else if (select == 5'h1D)
      comparator = 1'b1;
    else if (select == 5'h1E)
      comparator = (trial == 8'h00);
    else
      comparator = (lvl >= trial);
  end
  // pin shows port drive, else top bit of its source
  for (genvar i = 0; i < 8; i++)
    assign pad_in[i] = pad_oe[i] ? pad_out[i] : levels[8*i+7];
endmodule

// >>> dv/test_sadc_top.sv
`timescale 1ns/1ps
module test_sadc_top
  import sadc_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        xtal = 1'b0;
  logic        stop = 1'b0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [63:0] levels = 64'hC37F8001A55A00FF;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        apd, irq, dma, busy, comp;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  pad_out, pad_oe, port_read, trial, pad_in;
  logic [4:0]  asel;
  int          n_errors = 0;
  int          comparisons = 0;
  // ---------------------------------------------------------------
  // design and analog sources
  // ---------------------------------------------------------------
  sadc_top dut_u (.CORE_CLK(clk), .RESET(rst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .CRYSTAL_CLOCK(xtal), .STOP_MODE(stop),
    .COMPARATOR(comp), .PORT_DATA_OUT(8'hFF), .PORT_DIR_OUT(8'h0F),
    .PAD_IN(pad_in), .PAD_OUT(pad_out), .PAD_OE(pad_oe),
    .PORT_READ(port_read), .ANALOG_SELECT(asel), .ANALOG_TRIAL(trial),
    .ANALOG_POWER_DOWN(apd), .CPU_IRQ(irq), .DMA_REQ(dma),
    .CONV_BUSY(busy));
  sadc_analog_model src_u (.clk(clk), .levels(levels), .select(asel),
    .trial(trial), .power_down(apd), .pad_out(pad_out), .pad_oe(pad_oe),
    .comparator(comp), .pad_in(pad_in));
  // bus clock and a crystal clock at half its rate
  initial
    forever #20 clk = ~clk;
  always @(posedge clk)
    xtal <= ~xtal;
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic end_of_test();
    if (n_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ha;
    logic hw;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge clk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      @(posedge clk);
      if (ha)
        awvalid <= 1'b0;
      if (hw)
        wvalid <= 1'b0;
    end
    while ((awvalid && !ha) || (wvalid && !hw));
    do
      @(negedge clk);
    while (!bvalid);
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
      @(negedge clk);
    while (!arready);
    @(posedge clk);
    arvalid <= 1'b0;
    do
      @(negedge clk);
    while (!rvalid);
    d = rdata[7:0];
    r = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, exp);
  endtask
  task automatic wait_flag();
    logic [7:0] d;
    logic [1:0] r;
    d = 8'h00;
    for (int n = 0; n < 80 && !d[7]; n++)
      rd(8'h00, d, r);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] d;
    logic [1:0] r;
    rdc(8'h00, 8'h1F);
    rdc(8'h08, 8'h00);
    rd(8'h0C, d, r);
    chk({6'h00, r}, 8'h02);
    wr(8'h0C, 8'h00);
    chk({6'h00, bresp}, 8'h02);
  endtask
  task automatic t_single();
    wr(8'h08, 8'h10);
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h00, c[7:0]);
      wait_flag();
      chk(pad_oe, 8'h0F & ~(8'h01 << c));
      chk(pad_out[c], 1'b0);
      chk(port_read[c], 1'b0);
      rdc(8'h04, levels[8*c +: 8]);
      rdc(8'h00, c[7:0]);
      repeat (40) @(posedge clk);
      rdc(8'h00, c[7:0]);
    end
  endtask
  task automatic t_cont();
    wr(8'h00, 8'h22);
    wait_flag();
    rdc(8'h04, 8'h5A);
    levels[23:16] <= 8'h3C;
    repeat (60) @(posedge clk);
    rdc(8'h00, 8'h22);
    rdc(8'h04, 8'h3C);
    wr(8'h00, 8'h02);
    wait_flag();
    levels[23:16] <= 8'h5A;
    repeat (60) @(posedge clk);
    rdc(8'h04, 8'h3C);
  endtask
  task automatic t_irq();
    wr(8'h00, 8'h43);
    for (int n = 0; n < 80 && !irq; n++)
      @(negedge clk);
    chk(irq, 1'b1);
    chk(dma, 1'b0);
    rdc(8'h00, 8'h43);
    rdc(8'h04, 8'hA5);
    repeat (3) @(negedge clk);
    chk(irq, 1'b0);
    wr(8'h00, 8'hC3);
    for (int n = 0; n < 80 && !dma; n++)
      @(negedge clk);
    chk(dma, 1'b1);
    chk(irq, 1'b0);
    rdc(8'h00, 8'hC3);
    wr(8'h00, 8'h03);
    repeat (2) @(negedge clk);
    chk(dma, 1'b0);
    wait_flag();
  endtask
  task automatic t_stop();
    wr(8'h00, 8'h01);
    repeat (5) @(posedge clk);
    stop <= 1'b1;
    repeat (3) @(negedge clk);
    chk(busy, 1'b0);
    chk(apd, 1'b1);
    repeat (40) @(posedge clk);
    rdc(8'h00, 8'h01);
    stop <= 1'b0;
    wait_flag();
    rdc(8'h04, 8'h00);
  endtask
  task automatic t_presc();
    int n;
    int dv;
    for (int q = 0; q < 9; q++)
    begin
      dv = (q == 8) ? 2 : (q > 3) ? 16 : (1 << q);
      wr(8'h08, (q == 8) ? 8'h00 : {q[2:0], 5'h10});
      wr(8'h00, 8'h04);
      n = 0;
      while (busy && n < 400)
      begin
        @(negedge clk);
        n++;
      end
      chk(n >= 16*dv-3 && n <= 17*dv+3, 1'b1);
    end
  endtask
  task automatic t_off();
    wr(8'h00, 8'h1F);
    repeat (3) @(negedge clk);
    chk(apd, 1'b1);
    chk(busy, 1'b0);
  endtask
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_single();
    t_cont();
    t_irq();
    t_stop();
    t_presc();
    t_off();
    end_of_test();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
endmodule
